// [hdl/drfdma_buf_if.sv]
// Purpose: carrier between the fetch engine and its row buffers
// Assumes: same clock on both sides
// Notes:   bank 1 is the even buffer
`timescale 1ns/10ps
interface drfdma_buf_if #(parameter int IDX_W = 7, parameter int WIDTH = 8);
  logic             wr_en;
  logic             wr_bank;
  logic [IDX_W-1:0] wr_idx;
  logic [WIDTH-1:0] wr_data;
  logic             rd_bank;
  logic [IDX_W-1:0] rd_idx;
  logic [WIDTH-1:0] rd_data;

  modport ctl (output wr_en, wr_bank, wr_idx, wr_data, rd_bank, rd_idx, input rd_data);
  modport mem (input wr_en, wr_bank, wr_idx, wr_data, rd_bank, rd_idx, output rd_data);
endinterface

// [hdl/drfdma_defines.svh]
// Purpose: constants of the display row-fetch engine
// Assumes: 100 MHz CLOCK_I, one clock domain
// Notes:   offsets are Avalon byte addresses
`ifndef DRFDMA_DEFINES_SVH
`define DRFDMA_DEFINES_SVH

`define DRF_ROW_CHARS    80
`define DRF_CNT_W        7
`define DRF_ADDR_W       14
`define DRF_BLANK_CODE   8'h20
`define DRF_SCREEN_START 14'h3FFF
`define DRF_CODE_EOL     8'hCC
`define DRF_CODE_EOP     8'hCE
`define DRF_INV_BIT      1
`define DRF_ATTR_MSB     5
`define DRF_CHAR_MSB     6
`define DRF_ENTRY_INV    7
`define DRF_LINK_MSB     5

`define DRF_OFS_CTRL     4'h0
`define DRF_OFS_STATUS   4'h4
`define DRF_OFS_COUNT    4'h8
`define DRF_OFS_ADDR     4'hC
`define DRF_CTRL_EN_BIT  0
`define DRF_CTRL_RESET   1'b0

`endif

// [hdl/drfdma_pkg.sv]
// Purpose: types of the display row-fetch engine
// Assumes: nothing
// Notes:   Johnson codes step one bit at a time
package drfdma_pkg;

  typedef enum logic [2:0] {
    DRF_IDLE  = 3'h0,
    DRF_BID   = 3'h4,
    DRF_GRANT = 3'h6,
    DRF_REQ   = 3'h7,
    DRF_WAIT  = 3'h3,
    DRF_REL   = 3'h1
  } drfdma_state_type;

  typedef enum logic [2:0] {
    DRF_CHAR = 3'h0,
    DRF_CTRL = 3'h1,
    DRF_LINK = 3'h2,
    DRF_FLAG = 3'h3,
    DRF_EOL  = 3'h4,
    DRF_EOP  = 3'h5
  } drfdma_class_type;

endpackage

// [hdl/drfdma_row_mem.sv]
// Purpose: two ping-pong row buffers
// Assumes: indices stay below DEPTH
// Notes:   read data registered, one cycle latency
`timescale 1ns/10ps
module drfdma_row_mem #(
  parameter int DEPTH = 80,
  parameter int IDX_W = 7,
  parameter int WIDTH = 8
) (
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  drfdma_buf_if.mem    buf_if
);

  logic [WIDTH-1:0] mem_r [2][DEPTH];
  logic [WIDTH-1:0] rd_data_r;

  always_ff @(posedge clk_i) begin
    if (buf_if.wr_en) begin
      mem_r[buf_if.wr_bank][buf_if.wr_idx] <= buf_if.wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= mem_r[buf_if.rd_bank][buf_if.rd_idx];
    end
  end

  assign buf_if.rd_data = rd_data_r;

endmodule // drfdma_row_mem

// [hdl/drfdma_top.sv]
// Purpose: display row-fetch engine, bus sequencer and row buffers
// Assumes: pins asynchronous to CLOCK_I, synchronised here
// Notes:   address counter drives the bus in true polarity
`timescale 1ns/10ps
`include "drfdma_defines.svh"
module drfdma_top #(
  parameter int ROW_LEN = `DRF_ROW_CHARS,
  parameter int CNT_W   = `DRF_CNT_W,
  parameter int ADDR_W  = `DRF_ADDR_W
) (
  input  wire logic              CLOCK_I,
  input  wire logic              RST_I,
  input  wire logic [3:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  input  wire logic              ROW_START_PULSE_I,
  input  wire logic              VERTICAL_SYNC_PULSE_I,
  input  wire logic              PRIORITY_CHAIN_IN_I,
  input  wire logic              MEM_WAIT_I,
  input  wire logic [7:0]        MEM_DATA_I,
  input  wire logic              BUFFER_SELECT_I,
  input  wire logic              RECIRCULATE_PULSE_I,
  input  wire logic              RECIRCULATE_GATE_I,
  input  wire logic              FIRST_DOT_PULSE_I,
  output logic                   PRIORITY_CHAIN_OUT_N_O,
  output logic                   BUSY_N_O,
  output logic                   BUSY_OE_O,
  output logic      [ADDR_W-1:0] ADDR_O,
  output logic                   ADDR_OE_O,
  output logic                   MEM_REQ_N_O,
  output logic                   ATTRIBUTE_LATCH_STROBE_O,
  output logic      [5:0]        ATTRIBUTE_O,
  output logic                   INVERSE_VIDEO_O,
  output logic      [7:0]        DISPLAY_DATA_O
);

  // ==========================================================
  // Byte decode
  // ==========================================================
  function automatic drfdma_pkg::drfdma_class_type classify(input logic [7:0] b);
    drfdma_pkg::drfdma_class_type c;
    c = drfdma_pkg::DRF_FLAG;
    if (!b[7]) begin
      c = drfdma_pkg::DRF_CHAR;
    end else if (!b[6]) begin
      c = drfdma_pkg::DRF_CTRL;
    end else if (b[5] || b[4]) begin
      c = drfdma_pkg::DRF_LINK;
    end else if (b == `DRF_CODE_EOL) begin
      c = drfdma_pkg::DRF_EOL;
    end else if (b == `DRF_CODE_EOP) begin
      c = drfdma_pkg::DRF_EOP;
    end
    return c;
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(ROW_LEN);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  drfdma_pkg::drfdma_state_type state_r;
  drfdma_pkg::drfdma_state_type state_nxt;
  drfdma_pkg::drfdma_class_type hold_class;

  logic [15:0]       sync1_r;
  logic [15:0]       sync2_r;
  logic [3:0]        prev_r;
  logic              row_s;
  logic              vs_s;
  logic              prio_s;
  logic              wait_s;
  logic              even_s;
  logic              rpulse_s;
  logic              rgate_s;
  logic              dot_s;
  logic [7:0]        data_s;
  logic              row_go;
  logic              vs_go;
  logic              rc_step;
  logic              dot_go;

  logic [7:0]        hold_r;
  logic [ADDR_W-1:0] addr_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  rd_ptr_r;
  logic              eol_r;
  logic              eop_r;
  logic              link_r;
  logic              inv_r;
  logic [5:0]        attr_r;
  logic              strobe_r;
  logic [7:0]        disp_r;
  logic              enable_r;
  logic              ack_r;
  logic [31:0]       rdata_r;

  logic              pad;
  logic              run_ok;
  logic              cap;
  logic              rel_start;
  logic              rel_end;
  logic              decode_ok;
  logic              load_ch;
  logic              avs_req;
  logic              avs_wr;

  drfdma_buf_if #(.IDX_W(CNT_W), .WIDTH(8)) buf_if ();

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= {MEM_DATA_I, ROW_START_PULSE_I, VERTICAL_SYNC_PULSE_I, PRIORITY_CHAIN_IN_I, MEM_WAIT_I,
                  BUFFER_SELECT_I, RECIRCULATE_PULSE_I, RECIRCULATE_GATE_I, FIRST_DOT_PULSE_I};
      sync2_r <= sync1_r;
    end
  end

  assign data_s   = sync2_r[15:8];
  assign row_s    = sync2_r[7];
  assign vs_s     = sync2_r[6];
  assign prio_s   = sync2_r[5];
  assign wait_s   = sync2_r[4];
  assign even_s   = sync2_r[3];
  assign rpulse_s = sync2_r[2];
  assign rgate_s  = sync2_r[1];
  assign dot_s    = sync2_r[0];

  // Pulses act on their rising edge only, whatever their width
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      prev_r <= 4'h0;
    end else begin
      prev_r <= {row_s, vs_s, rpulse_s, dot_s};
    end
  end

  assign row_go  = row_s & ~prev_r[3];
  assign vs_go   = vs_s & ~prev_r[2];
  assign rc_step = rpulse_s & ~prev_r[1] & rgate_s;
  assign dot_go  = dot_s & ~prev_r[0];

  // ==========================================================
  // Bus sequencer
  // ==========================================================
  assign pad    = eol_r | eop_r;
  assign run_ok = enable_r && (cnt_r != CNT_END);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      drfdma_pkg::DRF_IDLE: begin
        if (run_ok) begin
          state_nxt = drfdma_pkg::DRF_BID;
        end
      end
      drfdma_pkg::DRF_BID: begin
        if (prio_s) begin
          state_nxt = drfdma_pkg::DRF_GRANT;
        end
      end
      drfdma_pkg::DRF_GRANT: begin
        state_nxt = drfdma_pkg::DRF_REQ;
      end
      drfdma_pkg::DRF_REQ: begin
        if (wait_s) begin
          state_nxt = drfdma_pkg::DRF_WAIT;
        end
      end
      drfdma_pkg::DRF_WAIT: begin
        state_nxt = drfdma_pkg::DRF_REL;
      end
      drfdma_pkg::DRF_REL: begin
        state_nxt = drfdma_pkg::DRF_IDLE;
      end
      default: begin
        state_nxt = drfdma_pkg::DRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_r <= drfdma_pkg::DRF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cap       = (state_r == drfdma_pkg::DRF_REQ) && wait_s;
  assign rel_start = (state_r == drfdma_pkg::DRF_WAIT);
  assign rel_end   = (state_r == drfdma_pkg::DRF_REL);
  assign decode_ok = rel_end && !link_r;

  // Johnson bits decoded, with state compares, into the bus strobes
  always_comb begin
    PRIORITY_CHAIN_OUT_N_O = ~(state_r[2] | (state_r == drfdma_pkg::DRF_BID));
    BUSY_N_O               = ~(state_r[2] & state_r[1] | (state_r == drfdma_pkg::DRF_WAIT));
    BUSY_OE_O              = ~BUSY_N_O;
    ADDR_OE_O              = ~BUSY_N_O;
    MEM_REQ_N_O            = ~((state_r == drfdma_pkg::DRF_REQ) && !pad);
  end

  assign ADDR_O = addr_r;

  // ==========================================================
  // Holding register and flags
  // ==========================================================
  assign hold_class = classify(hold_r);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      hold_r <= 8'h00;
    end else if (cap && !link_r) begin
      hold_r <= pad ? `DRF_BLANK_CODE : data_s;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      link_r <= 1'b0;
    end else if (rel_end) begin
      link_r <= !link_r && !pad && (hold_class == drfdma_pkg::DRF_LINK);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      eol_r <= 1'b0;
    end else if (decode_ok && (hold_class == drfdma_pkg::DRF_EOL)) begin
      eol_r <= 1'b1;
    end else if (cnt_r == CNT_END) begin
      eol_r <= 1'b0;
    end
  end

  // Set wins over vertical sync in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      eop_r <= 1'b0;
    end else if (decode_ok && (hold_class == drfdma_pkg::DRF_EOP)) begin
      eop_r <= 1'b1;
    end else if (vs_go) begin
      eop_r <= 1'b0;
    end
  end

  // ==========================================================
  // Address counter
  // ==========================================================
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      addr_r <= `DRF_SCREEN_START;
    end else if (vs_go) begin
      addr_r <= `DRF_SCREEN_START;
    end else if (rel_start && link_r) begin
      addr_r <= ADDR_W'({hold_r[`DRF_LINK_MSB:0], data_s});
    end else if (decode_ok && !pad) begin
      addr_r <= addr_r - ADDR_W'(1);
    end
  end

  // ==========================================================
  // Character counter
  // ==========================================================
  // Flag bytes fall through here untouched
  assign load_ch = decode_ok && (hold_class == drfdma_pkg::DRF_CHAR) && (cnt_r != CNT_END);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cnt_r <= CNT_END;
    end else if (row_go) begin
      cnt_r <= '0;
    end else if (load_ch) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // ==========================================================
  // Enhancement latches
  // ==========================================================
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      inv_r  <= 1'b0;
      attr_r <= 6'h00;
    end else if (decode_ok && pad) begin
      inv_r  <= 1'b0;
      attr_r <= 6'h00;
    end else if (decode_ok && (hold_class == drfdma_pkg::DRF_CTRL)) begin
      inv_r  <= hold_r[`DRF_INV_BIT];
      attr_r <= hold_r[`DRF_ATTR_MSB:0];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= decode_ok && (pad || (hold_class == drfdma_pkg::DRF_CTRL));
    end
  end

  assign ATTRIBUTE_LATCH_STROBE_O = strobe_r;
  assign ATTRIBUTE_O              = attr_r;
  assign INVERSE_VIDEO_O          = inv_r;

  // ==========================================================
  // Row buffers
  // ==========================================================
  assign buf_if.wr_en   = load_ch;
  assign buf_if.wr_bank = ~even_s;
  assign buf_if.wr_idx  = cnt_r;
  assign buf_if.wr_data = {inv_r & ~pad, hold_r[`DRF_CHAR_MSB:0]};
  assign buf_if.rd_bank = even_s;
  assign buf_if.rd_idx  = rd_ptr_r;

  // One full turn per scan line keeps entry 0 aligned
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rd_ptr_r <= '0;
    end else if (row_go) begin
      rd_ptr_r <= '0;
    end else if (rc_step) begin
      rd_ptr_r <= (rd_ptr_r == CNT_END - CNT_ONE) ? '0 : rd_ptr_r + CNT_ONE;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      disp_r <= 8'h00;
    end else if (dot_go) begin
      disp_r <= buf_if.rd_data;
    end
  end

  assign DISPLAY_DATA_O = disp_r;

  drfdma_row_mem #(
    .DEPTH (ROW_LEN),
    .IDX_W (CNT_W),
    .WIDTH (8)
  ) u_row_mem (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .buf_if (buf_if)
  );

  // ==========================================================
  // Avalon slave
  // ==========================================================
  // Fixed one wait cycle: simple and independent of decode
  assign avs_req = AVS_READ_I | AVS_WRITE_I;
  assign avs_wr  = AVS_WRITE_I & ack_r;
  assign AVS_WAITREQUEST_O = avs_req & ~ack_r;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= avs_req & ~ack_r;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      enable_r <= `DRF_CTRL_RESET;
    end else if (avs_wr && (AVS_ADDRESS_I == `DRF_OFS_CTRL)) begin
      enable_r <= AVS_WRITEDATA_I[`DRF_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack_r) begin
      case (AVS_ADDRESS_I)
        `DRF_OFS_CTRL:   rdata_r <= {31'h0, enable_r};
        `DRF_OFS_STATUS: rdata_r <= {24'h0, even_s, inv_r, link_r, eop_r, eol_r, state_r};
        `DRF_OFS_COUNT:  rdata_r <= {25'h0, cnt_r};
        `DRF_OFS_ADDR:   rdata_r <= {18'h0, addr_r};
        default:         rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_READDATA_O = rdata_r;

endmodule // drfdma_top

// [tb/drfdma_assertions.sv]
// Purpose: bus sequencer checks on the top ports
// Assumes: one clock, synchronous reset
// Notes:   sequencer state is seen through its decoded strobes
`timescale 1ns/10ps
module drfdma_assertions #(
  parameter int ADDR_W = 14
) (
  input wire logic              CLOCK_I,
  input wire logic              RST_I,
  input wire logic              PRIORITY_CHAIN_OUT_N_O,
  input wire logic              BUSY_N_O,
  input wire logic              BUSY_OE_O,
  input wire logic [ADDR_W-1:0] ADDR_O,
  input wire logic              ADDR_OE_O,
  input wire logic              MEM_REQ_N_O,
  input wire logic              ATTRIBUTE_LATCH_STROBE_O,
  input wire logic [5:0]        ATTRIBUTE_O,
  input wire logic              INVERSE_VIDEO_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // ========
  // Sequencer steps
  sequence s_held; !PRIORITY_CHAIN_OUT_N_O && BUSY_OE_O; endsequence
  sequence s_wait; PRIORITY_CHAIN_OUT_N_O && BUSY_OE_O; endsequence
  property p_bid_to_grant;
    $rose(BUSY_OE_O) |-> !PRIORITY_CHAIN_OUT_N_O && $past(PRIORITY_CHAIN_OUT_N_O) == 1'b0;
  endproperty
  a_bid_to_grant: assert property (p_bid_to_grant) else $error("bus taken without a bid");
  property p_oe_pair;
    ADDR_OE_O == BUSY_OE_O;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("address drivers apart from busy");
  property p_busy_rel;
    $fell(BUSY_OE_O) |-> BUSY_N_O && MEM_REQ_N_O && $past(PRIORITY_CHAIN_OUT_N_O);
  endproperty
  a_busy_rel: assert property (p_busy_rel) else $error("busy released before wait state");
  property p_req_in_grant;
    !MEM_REQ_N_O |-> s_held;
  endproperty
  a_req_in_grant: assert property (p_req_in_grant) else $error("request outside request state");
  property p_min_cycle;
    $rose(BUSY_OE_O) |-> BUSY_OE_O [*3];
  endproperty
  a_min_cycle: assert property (p_min_cycle) else $error("bus cycle too short");
  property p_wait_rel;
    s_held ##1 s_wait |-> MEM_REQ_N_O ##1 (!BUSY_OE_O && PRIORITY_CHAIN_OUT_N_O);
  endproperty
  a_wait_rel: assert property (p_wait_rel) else $error("wait not followed by release");
  property p_addr_hold;
    ADDR_OE_O && $past(ADDR_OE_O) |-> $stable(ADDR_O);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved on the bus");
  property p_strobe_inv;
    ATTRIBUTE_LATCH_STROBE_O |-> INVERSE_VIDEO_O == ATTRIBUTE_O[1];
  endproperty
  a_strobe_inv: assert property (p_strobe_inv) else $error("inverse latch differs from bit 1");
  property p_strobe_pulse;
    ATTRIBUTE_LATCH_STROBE_O |-> !BUSY_OE_O ##1 !ATTRIBUTE_LATCH_STROBE_O;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe not a single pulse");
endmodule // drfdma_assertions

bind drfdma_top drfdma_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .PRIORITY_CHAIN_OUT_N_O(PRIORITY_CHAIN_OUT_N_O),
  .BUSY_N_O(BUSY_N_O), .BUSY_OE_O(BUSY_OE_O), .ADDR_O(ADDR_O), .ADDR_OE_O(ADDR_OE_O),
  .MEM_REQ_N_O(MEM_REQ_N_O), .ATTRIBUTE_LATCH_STROBE_O(ATTRIBUTE_LATCH_STROBE_O),
  .ATTRIBUTE_O(ATTRIBUTE_O), .INVERSE_VIDEO_O(INVERSE_VIDEO_O));

// [tb/drfdma_mem_model.sv]
// Purpose: backplane memory and priority chain beside the engine
// Assumes: bench fills mem before a fetch
// Notes:   wait is raised for pseudo reads too, data then floats high
`timescale 1ns/10ps
module drfdma_mem_model (
  input  wire logic        clk_i,
  input  wire logic [13:0] addr_i,
  input  wire logic        addr_oe_i,
  input  wire logic        req_n_i,
  input  wire logic        chain_n_i,
  input  wire logic        stall_i,
  input  wire logic        slow_i,
  output logic             prio_o,
  output logic             wait_o,
  output logic [7:0]       data_o
);
  logic [7:0] mem [0:16383];
  int         cnt = 0;
  // ========
  // Read cycle
  always @(posedge clk_i) begin
    prio_o <= !stall_i;
    if (addr_oe_i && !chain_n_i) begin
      cnt <= cnt + 1;
      if (cnt == (slow_i ? 9 : 2) && !req_n_i) data_o <= mem[addr_i];
      // Data settles well before wait so the sync flops agree
      if (cnt == (slow_i ? 14 : 6)) wait_o <= 1'b1;
    end else begin
      cnt <= 0;
      wait_o <= 1'b0;
      data_o <= 8'hFF;
    end
  end
endmodule // drfdma_mem_model

// [tb/tb_top.sv]
// Purpose: self-checking bench of the row-fetch engine
// Assumes: default row length of 80
// Notes:   row buffers are read back through the display latch
`timescale 1ns/10ps
module tb_top;
  typedef struct { logic [13:0] a; logic [7:0] b; int r; logic [7:0] e; } drfdma_tbrow_type;
  logic             clk = 1'b0, rst = 1'b1, av_rd = 1'b0, av_wr = 1'b0, av_wait;
  logic [3:0]       av_addr = 4'h0;
  logic [31:0]      av_wdata = 32'h0, av_rdata, q;
  logic             row_start = 1'b0, vsync = 1'b0, sel = 1'b0, recirc = 1'b0, gate = 1'b0;
  logic             dot = 1'b0, stall = 1'b0, slow = 1'b0;
  logic             prio, mwait, chain_n, busy_n, busy_oe, addr_oe, req_n, strobe, inv;
  logic [7:0]       mdata, disp;
  logic [13:0]      addr;
  logic [5:0]       attr;
  logic [7:0]       exp_row [3][80];
  logic [5:0]       strobe_q [$];
  int               bad_count = 0, comparisons = 0, pos [3];
  drfdma_tbrow_type rows [15] = '{
    '{14'h3FFF, 8'h41, 0, 8'h41}, '{14'h3FFE, 8'h82, 0, 8'h00}, '{14'h3FFD, 8'h42, 0, 8'hC2},
    '{14'h3FFC, 8'h80, 0, 8'h00}, '{14'h3FFB, 8'hC3, 0, 8'h00}, '{14'h3FFA, 8'hE1, 0, 8'h00},
    '{14'h3FF9, 8'h50, 0, 8'h00}, '{14'h2150, 8'h43, 0, 8'h43}, '{14'h214F, 8'hCC, 0, 8'h00},
    '{14'h214E, 8'hBD, 1, 8'h00}, '{14'h214D, 8'h44, 1, 8'h44}, '{14'h214C, 8'hD0, 1, 8'h00},
    '{14'h214B, 8'h00, 1, 8'h00}, '{14'h1000, 8'h45, 1, 8'h45}, '{14'h0FFF, 8'hCE, 1, 8'h00}};

  always #5 clk = ~clk;
  always @(posedge clk) if (strobe === 1'b1) strobe_q.push_back(attr);

  drfdma_top uut (
    .CLOCK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
    .AVS_WRITEDATA_I(av_wdata), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
    .ROW_START_PULSE_I(row_start), .VERTICAL_SYNC_PULSE_I(vsync), .PRIORITY_CHAIN_IN_I(prio),
    .MEM_WAIT_I(mwait), .MEM_DATA_I(mdata), .BUFFER_SELECT_I(sel), .RECIRCULATE_PULSE_I(recirc),
    .RECIRCULATE_GATE_I(gate), .FIRST_DOT_PULSE_I(dot), .PRIORITY_CHAIN_OUT_N_O(chain_n),
    .BUSY_N_O(busy_n), .BUSY_OE_O(busy_oe), .ADDR_O(addr), .ADDR_OE_O(addr_oe), .MEM_REQ_N_O(req_n),
    .ATTRIBUTE_LATCH_STROBE_O(strobe), .ATTRIBUTE_O(attr), .INVERSE_VIDEO_O(inv),
    .DISPLAY_DATA_O(disp));

  drfdma_mem_model mdl (
    .clk_i(clk), .addr_i(addr), .addr_oe_i(addr_oe), .req_n_i(req_n), .chain_n_i(chain_n),
    .stall_i(stall), .slow_i(slow), .prio_o(prio), .wait_o(mwait), .data_o(mdata));

  // ========
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_addr <= a; av_wr <= wr; av_rd <= !wr; av_wdata <= d;
    do begin @(posedge clk); n++; end while (av_wait !== 1'b0 && n < 20);
    q = av_rdata;
    if (n >= 20) chk("avalon answer", 32'h0, 32'h1);
    av_wr <= 1'b0; av_rd <= 1'b0;
  endtask

  task automatic pins(input int k, input logic v);
    @(posedge clk);
    case (k) 0: row_start <= v; 1: vsync <= v; 2: recirc <= v; default: dot <= v; endcase
  endtask

  // Pulses outlast the pin synchronisers
  task automatic pulse(input int k);
    pins(k, 1'b1); repeat (4) @(posedge clk);
    pins(k, 1'b0); repeat (6) @(posedge clk);
  endtask

  task automatic readback(input logic s, input int r);
    @(posedge clk); sel <= s; gate <= 1'b0;
    pulse(2);
    @(posedge clk); gate <= 1'b1;
    for (int j = 0; j < 80; j++) begin
      pulse(3);
      chk("display entry", {24'h0, disp}, {24'h0, exp_row[r][j]});
      pulse(2);
    end
  endtask

  task automatic run_row(input logic s);
    int n;
    n = 0;
    @(posedge clk); sel <= s;
    strobe_q.delete();
    pulse(0);
    do begin avs(1'b0, 4'h8, 32'h0); n++; end while (q[6:0] !== 7'h50 && n < 2000);
    chk("row count", q, 32'h50);
    repeat (20) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ========
  // Main sequence
  initial begin
    foreach (exp_row[i, j]) exp_row[i][j] = 8'h20;
    foreach (rows[i]) begin
      mdl.mem[rows[i].a] = rows[i].b;
      if (rows[i].e != 8'h00) exp_row[rows[i].r][pos[rows[i].r]++] = rows[i].e;
    end
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    avs(1'b0, 4'h0, 32'h0); chk("ctrl reset", q, 32'h0);
    avs(1'b0, 4'h2, 32'h0); chk("unmapped read", q, 32'h0);
    pulse(1);
    pulse(0);
    repeat (10) @(posedge clk);
    chk("no bid when off", {31'h0, chain_n}, 32'h1);
    // Grant held back so the early bid cannot fetch before the row starts
    @(posedge clk); stall <= 1'b1;
    fork begin repeat (80) @(posedge clk); stall <= 1'b0; end join_none
    repeat (4) @(posedge clk);
    avs(1'b1, 4'h0, 32'h1); avs(1'b0, 4'h0, 32'h0); chk("ctrl enable", q, 32'h1);
    avs(1'b0, 4'hC, 32'h0); chk("screen start", q, 32'h3FFF);
    chk("bid without grant", {30'h0, chain_n, busy_oe}, 32'h0);
    run_row(1'b0);
    chk("control attr", {26'h0, strobe_q[0]}, 32'h02);
    chk("control clear", {26'h0, strobe_q[1]}, 32'h00);
    chk("pad attr", {25'h0, inv, attr}, 32'h0);
    avs(1'b0, 4'hC, 32'h0); chk("frozen at line end", q, 32'h214E);
    avs(1'b0, 4'h4, 32'h0); chk("line end cleared", {31'h0, q[3]}, 32'h0);
    readback(1'b1, 0);
    @(posedge clk); slow <= 1'b1;
    run_row(1'b1);
    chk("control bits", {26'h0, strobe_q[0]}, 32'h3D);
    avs(1'b0, 4'h4, 32'h0); chk("page end set", {31'h0, q[4]}, 32'h1);
    readback(1'b1, 0);
    readback(1'b0, 1);
    @(posedge clk); slow <= 1'b0;
    run_row(1'b0);
    avs(1'b0, 4'hC, 32'h0); chk("frozen at page end", q, 32'h0FFE);
    readback(1'b1, 2);
    pulse(1);
    avs(1'b0, 4'h4, 32'h0); chk("page end cleared", {31'h0, q[4]}, 32'h0);
    avs(1'b0, 4'hC, 32'h0); chk("vsync restart", q, 32'h3FFF);
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule // tb_top
